// file: rtl/gain_ctl_map.svh
// constants for the gain, mute and channel control port
`ifndef GAIN_CTL_MAP_SVH
`define GAIN_CTL_MAP_SVH
`define DEV_ADDR_BYTE 8'hEC
`define GAIN_MSB 7
`define GAIN_LSB 3
`define MUTE_BIT 2
`define LEFT_EN_BIT 1
`define RIGHT_EN_BIT 0
`define CTRL_RESET 8'h00
`define BIT_CNT_LAST 4'h8
`define BIT_CNT_ZERO 4'h0
`define WAKE_TIME_US 400
`define CLK_MHZ 100
`define WAKE_CYCLES (`WAKE_TIME_US * `CLK_MHZ)
`define MUTE_DB 8'shB4
`endif

// file: rtl/gain_ctl_pkg.sv
// types shared by the control port modules
`default_nettype none
package gain_ctl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_IGNORE
    } bus_state_t;
    typedef logic signed [7:0] gain_db_t;
endpackage : gain_ctl_pkg
`default_nettype wire

// file: rtl/line_sync_if.sv
// carrier for the synchronised bus lines and their edge events
`default_nettype none
interface line_sync_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport dst (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : line_sync_if
`default_nettype wire

// file: rtl/line_sync.sv
// two-stage synchronisers and edge detection for scl and sda
`default_nettype none
module line_sync (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    line_sync_if.src lines
);
    logic [1:0] scl_meta_ff; // first stage only feeds second
    logic [1:0] sda_meta_ff;
    logic scl_ff;
    logic sda_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;
    // idle bus lines are high, so reset to one
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_meta_ff <= 2'b11;
            sda_meta_ff <= 2'b11;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_meta_ff <= {scl_meta_ff[0], scl_in};
            sda_meta_ff <= {sda_meta_ff[0], sda_in};
            scl_prev_ff <= scl_ff;
            sda_prev_ff <= sda_ff;
        end
    end
    assign scl_ff = scl_meta_ff[1];
    assign sda_ff = sda_meta_ff[1];
    assign lines.scl = scl_ff;
    assign lines.sda = sda_ff;
    assign lines.scl_rise = scl_ff & ~scl_prev_ff;
    assign lines.scl_fall = ~scl_ff & scl_prev_ff;
    // sda moving while scl stays high marks start or stop
    assign lines.start_det = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
    assign lines.stop_det = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;
endmodule : line_sync
`default_nettype wire

// file: rtl/gain_mute_ctl.sv
// write-only two-wire control port with gain, mute and channel enables
// Contract
// R1: start condition begins address compare
// R2: respond only to address byte 0xEC
// R3: sample bits on rising scl
// R4: master keeps sda stable while scl high
// R5: drive ack low after matched address
// R6: master abandons transfer on missing ack
// R7: shift data byte into control register
// R8: acknowledge every data byte
// R9: accept further bytes until stop
// R10: stop returns port to idle
// R11: master leaves sda high when idle
// R12: master keeps scl at most 400 kHz
// R13: gain bits 7-3, mute 2, left 1, right 0
// R14: map gain code to decibel table
// R15: both enables clear means shutdown
// R16: wait 400 us wake-up before active
// R17: mute forces gain to mute level
// R18: control register resets to zero
`include "gain_ctl_map.svh"
`default_nettype none
module gain_mute_ctl #(
    parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [7:0] ctrl_reg_out,
    output logic signed [7:0] gain_db_out,
    output logic mute_out,
    output logic left_channel_enable_out,
    output logic right_channel_enable_out,
    output logic shutdown_out,
    output logic outputs_active_out,
    output logic byte_written_out
);
    line_sync_if lines ();
    gain_ctl_pkg::bus_state_t state_ff; // bus sequencer state
    gain_ctl_pkg::bus_state_t nxt_state;
    logic [3:0] bit_cnt_ff; // bits taken in current byte
    logic [3:0] nxt_bit_cnt;
    logic [7:0] shift_ff; // incoming byte, msb first
    logic [7:0] ctrl_ff; // the control register
    logic ack_ff; // sda pulled low for acknowledge
    logic nxt_ack;
    logic addr_match_ff; // latched compare of the address byte
    logic wr_pulse_ff; // one cycle after each load
    logic [16:0] wake_cnt_ff; // wake-up counter, counts up from zero
    logic active_ff;
    gain_ctl_pkg::gain_db_t gain_db_ff;
    logic [7:0] byte_done;
    logic byte_full;
    logic addr_match;
    logic load_ctrl;
    logic all_off;
    logic [4:0] gain_code;
    gain_ctl_pkg::gain_db_t table_db;

    line_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .lines(lines)
    );

    // full byte includes the bit sampled on this rising edge
    assign byte_done = {shift_ff[6:0], lines.sda}; // [R3]
    assign byte_full = lines.scl_rise && (bit_cnt_ff == `BIT_CNT_LAST - 4'h1);
    assign addr_match = (byte_done == `DEV_ADDR_BYTE); // [R2]
    assign load_ctrl = (state_ff == gain_ctl_pkg::ST_DATA)
        && byte_full; // [R7]

    // sequencer; start and stop win over any bit activity
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_ack = ack_ff;
        if (lines.start_det) begin
            nxt_state = gain_ctl_pkg::ST_ADDR; // [R1]
            nxt_bit_cnt = `BIT_CNT_ZERO;
            nxt_ack = 1'b0;
        end else if (lines.stop_det) begin
            nxt_state = gain_ctl_pkg::ST_IDLE; // [R10]
            nxt_ack = 1'b0;
        end else begin
            unique case (state_ff)
                gain_ctl_pkg::ST_IDLE, gain_ctl_pkg::ST_IGNORE: begin
                    nxt_ack = 1'b0;
                end
                gain_ctl_pkg::ST_ADDR, gain_ctl_pkg::ST_DATA: begin
                    if (lines.scl_rise) begin
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end
                    // ack is raised after the eighth falling edge
                    if (lines.scl_fall && bit_cnt_ff == `BIT_CNT_LAST) begin
                        if (state_ff == gain_ctl_pkg::ST_DATA
                            || addr_match_ff) begin
                            nxt_state = (state_ff == gain_ctl_pkg::ST_DATA)
                                ? gain_ctl_pkg::ST_DATA_ACK
                                : gain_ctl_pkg::ST_ADDR_ACK;
                            nxt_ack = 1'b1; // [R5] [R8]
                        end else begin
                            nxt_state = gain_ctl_pkg::ST_IGNORE;
                        end
                    end
                end
                gain_ctl_pkg::ST_ADDR_ACK, gain_ctl_pkg::ST_DATA_ACK: begin
                    // release after the ninth pulse falls
                    if (lines.scl_fall) begin
                        nxt_ack = 1'b0;
                        nxt_bit_cnt = `BIT_CNT_ZERO;
                        nxt_state = gain_ctl_pkg::ST_DATA; // [R9]
                    end
                end
            endcase
        end
    end

    // sequencer registers; address compare latched at its last bit
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= gain_ctl_pkg::ST_IDLE;
            bit_cnt_ff <= `BIT_CNT_ZERO;
            ack_ff <= 1'b0;
            addr_match_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            ack_ff <= nxt_ack;
            if (state_ff == gain_ctl_pkg::ST_ADDR && byte_full) begin
                addr_match_ff <= addr_match;
            end
        end
    end

    // shifter and control register
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_ff <= `CTRL_RESET;
            ctrl_ff <= `CTRL_RESET; // [R18]
            wr_pulse_ff <= 1'b0;
        end else begin
            if (lines.scl_rise) begin
                shift_ff <= byte_done; // [R3]
            end
            if (load_ctrl) begin
                ctrl_ff <= byte_done; // [R7]
            end
            wr_pulse_ff <= load_ctrl;
        end
    end

    // field split of the control byte
    assign gain_code = ctrl_ff[`GAIN_MSB:`GAIN_LSB]; // [R13]
    assign all_off = ~ctrl_ff[`LEFT_EN_BIT] & ~ctrl_ff[`RIGHT_EN_BIT];

    // gain code to decibels, 00011 taken as -44
    always_comb begin
        unique case (gain_code) // [R14]
            5'h00: table_db = -8'sd76;
            5'h01: table_db = -8'sd62;
            5'h02: table_db = -8'sd52;
            5'h03: table_db = -8'sd44;
            5'h04: table_db = -8'sd38;
            5'h05: table_db = -8'sd34;
            5'h06: table_db = -8'sd30;
            5'h07: table_db = -8'sd27;
            5'h08: table_db = -8'sd24;
            5'h09: table_db = -8'sd21;
            5'h0A: table_db = -8'sd18;
            5'h0B: table_db = -8'sd16;
            5'h0C: table_db = -8'sd14;
            5'h0D: table_db = -8'sd12;
            5'h0E: table_db = -8'sd10;
            5'h0F: table_db = -8'sd8;
            5'h10: table_db = -8'sd6;
            5'h11: table_db = -8'sd4;
            5'h12: table_db = -8'sd2;
            5'h13: table_db = 8'sd0;
            5'h14: table_db = 8'sd2;
            5'h15: table_db = 8'sd4;
            5'h16: table_db = 8'sd6;
            5'h17: table_db = 8'sd8;
            5'h18: table_db = 8'sd10;
            5'h19: table_db = 8'sd12;
            5'h1A: table_db = 8'sd13;
            5'h1B: table_db = 8'sd14;
            5'h1C: table_db = 8'sd15;
            5'h1D: table_db = 8'sd16;
            5'h1E: table_db = 8'sd17;
            5'h1F: table_db = 8'sd18;
        endcase
    end

    // wake-up timer; restarts whenever shutdown is entered
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_cnt_ff <= 17'h0_0000;
            active_ff <= 1'b0;
            gain_db_ff <= `MUTE_DB;
        end else begin
            gain_db_ff <= ctrl_ff[`MUTE_BIT] ? `MUTE_DB : table_db; // [R17]
            if (all_off) begin
                wake_cnt_ff <= 17'h0_0000; // [R15]
                active_ff <= 1'b0;
            end else if (!active_ff) begin
                if (wake_cnt_ff == 17'(WAKE_CYCLES - 1)) begin
                    active_ff <= 1'b1; // [R16]
                end
                wake_cnt_ff <= wake_cnt_ff + 17'h0_0001;
            end
        end
    end

    // open-drain: drive only a low, only while acknowledging
    assign sda_out = 1'b0;
    assign sda_oe_out = ack_ff; // [R5] [R8]
    assign ctrl_reg_out = ctrl_ff;
    assign gain_db_out = gain_db_ff;
    assign mute_out = ctrl_ff[`MUTE_BIT];
    assign left_channel_enable_out = ctrl_ff[`LEFT_EN_BIT];
    assign right_channel_enable_out = ctrl_ff[`RIGHT_EN_BIT];
    assign shutdown_out = all_off; // [R15]
    assign outputs_active_out = active_ff;
    assign byte_written_out = wr_pulse_ff;

    mismatch_no_ack_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (state_ff == gain_ctl_pkg::ST_IGNORE) |-> !sda_oe_out) // [R2]
        else $error("ack driven for foreign address");
    start_to_addr_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        lines.start_det |=> (state_ff == gain_ctl_pkg::ST_ADDR)) // [R1]
        else $error("start not taken");
    stop_to_idle_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        lines.stop_det && !lines.start_det
        |=> (state_ff == gain_ctl_pkg::ST_IDLE) && !sda_oe_out) // [R10]
        else $error("stop did not idle");
    // ack held from its raise until the ninth pulse falls
    sequence ack_holding_s;
        sda_oe_out && !lines.scl_fall
            && !lines.start_det && !lines.stop_det;
    endsequence
    // register shows the byte while the one-cycle pulse stands
    sequence byte_loaded_s;
        (ctrl_ff == $past(byte_done)) && byte_written_out;
    endsequence
    // eighth data bit done and its clock pulse ends
    sequence data_byte_end_s;
        (state_ff == gain_ctl_pkg::ST_DATA) && (bit_cnt_ff == `BIT_CNT_LAST)
            && lines.scl_fall && !lines.start_det && !lines.stop_det;
    endsequence
    ack_hold_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        ack_holding_s |=> sda_oe_out) // [R5]
        else $error("ack dropped early");
    data_load_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        load_ctrl |=> byte_loaded_s ##1 !byte_written_out) // [R7]
        else $error("control byte not loaded");
    data_ack_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        data_byte_end_s |=> sda_oe_out) // [R8]
        else $error("data byte not acknowledged");
    mute_force_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        ctrl_ff[`MUTE_BIT] |=> (gain_db_ff == `MUTE_DB)) // [R17]
        else $error("mute not forcing gain");
    shut_inactive_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        all_off |=> !outputs_active_out) // [R15]
        else $error("active while shut down");
    wake_early_a: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        $rose(active_ff) |-> $past(wake_cnt_ff)
        == 17'(WAKE_CYCLES - 1)) // [R16]
        else $error("woke before interval");
endmodule : gain_mute_ctl
`default_nettype wire

// file: tb/two_wire_master.sv
// bus master model that drives the two-wire control port
`default_nettype none
module two_wire_master #(
    parameter int HALF = 125 // clk cycles per scl phase
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: both lines released high
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // all moves land on falling clock edges
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wait_clk
    // sda falls while scl is high
    task automatic start();
        wait_clk(HALF);
        sda_low_out = 1'b1;
        wait_clk(HALF);
        scl_out = 1'b0;
    endtask : start
    // n bits msb first, then an ack pulse only for a whole byte
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            wait_clk(10);
            sda_low_out = ~b[i]; // data moves only while scl low
            wait_clk(HALF - 10);
            scl_out = 1'b1; // two phases of HALF keep 400 kHz
            wait_clk(HALF);
            scl_out = 1'b0;
        end
        if (n == 8) begin
            wait_clk(10);
            sda_low_out = 1'b0; // released so the port can pull low
            wait_clk(HALF - 10);
            scl_out = 1'b1;
            ack = ~sda_in;
            wait_clk(HALF);
            ack = ack & ~sda_in; // low both when scl rises and just before it falls
            scl_out = 1'b0;
        end
    endtask : send
    // sda rises while scl is high
    task automatic stop();
        wait_clk(10);
        sda_low_out = 1'b1;
        wait_clk(HALF - 10);
        scl_out = 1'b1;
        wait_clk(HALF);
        sda_low_out = 1'b0;
        wait_clk(HALF);
    endtask : stop
endmodule : two_wire_master
`default_nettype wire

// file: tb/gain_mute_ctl_tb.sv
// self-checking bench for the gain, mute and channel control port
`default_nettype none
module gain_mute_ctl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAKE = 20; // shortened charge pump wait
    typedef struct packed {logic [7:0] data; logic [7:0] gain;} row_t;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic scl, sda_low, sda_oe, sda_drv, sda_line, ack;
    logic [7:0] ctrl, gain_db;
    logic mute, left_en, right_en, shut, active, written;
    int fail_count = 0;
    int comparisons = 0;
    int writes = 0;
    int since_on = 0;
    int wake_seen = -1;
    logic [7:0] bad_addr [2] = '{8'h6C, 8'hED};
    // control byte beside the gain it should give, in dB
    row_t rows [11] = '{'{8'h00, 8'hB4}, '{8'h1B, 8'hD4},
        '{8'h9A, 8'h00}, '{8'hA1, 8'h02}, '{8'hFD, 8'hB4},
        '{8'hF9, 8'h12}, '{8'h0A, 8'hC2}, '{8'h7E, 8'hB4},
        '{8'h7A, 8'hF8}, '{8'hD3, 8'h0D}, '{8'h04, 8'hB4}};
    // open-drain line with pull-up
    assign sda_line = (sda_oe ? sda_drv : 1'b1) & ~sda_low;
    always #5 clk_sys_in = ~clk_sys_in;
    two_wire_master mdl (.clk_in(clk_sys_in), .sda_in(sda_line),
        .scl_out(scl), .sda_low_out(sda_low));
    gain_mute_ctl #(.WAKE_CYCLES(WAKE)) uut (.clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .ctrl_reg_out(ctrl),
        .gain_db_out(gain_db), .mute_out(mute),
        .left_channel_enable_out(left_en),
        .right_channel_enable_out(right_en), .shutdown_out(shut),
        .outputs_active_out(active), .byte_written_out(written));
    // count load pulses and time the wake-up, on settled values
    always @(negedge clk_sys_in) begin
        if (written === 1'b1) writes++;
        since_on <= (shut === 1'b1) ? 0 : since_on + 1;
        if (active === 1'b1 && wake_seen < 0) wake_seen = since_on;
    end
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("counts: %0d compared, %0d failed", comparisons,
                 fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        fail_count++;
        $display("[ERR] watchdog expected finish seen hang");
        print_verdict();
    end
    initial begin
        repeat (20) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        check("ctrl rst", ctrl, 8'h00);
        check("gain rst", gain_db, 8'hB4);
        check("shut rst", {7'h00, shut}, 8'h01);
        check("act rst", {7'h00, active}, 8'h00);
        $display("test reset done");
        // one transfer carries every row as a further data byte
        mdl.start();
        mdl.send(8'hEC, 8, ack);
        check("addr ack", {7'h00, ack}, 8'h01);
        foreach (rows[i]) begin
            mdl.send(rows[i].data, 8, ack);
            check("data ack", {7'h00, ack}, 8'h01);
            check("ctrl", ctrl, rows[i].data);
            check("gain", gain_db, rows[i].gain);
            check("bits", {4'h0, mute, left_en, right_en, shut},
                {4'h0, rows[i].data[2:0],
                rows[i].data[1:0] == 2'b00});
            check("active", {7'h00, active},
                {7'h00, |rows[i].data[1:0]});
        end
        mdl.stop();
        check("loads", writes[7:0], 8'h0B);
        check("wake", {7'h00, wake_seen >= WAKE - 1 &&
            wake_seen <= WAKE + 2}, 8'h01);
        $display("test rows done");
        // foreign addresses: no ack, data ignored, master gives up
        foreach (bad_addr[i]) begin
            mdl.start();
            mdl.send(bad_addr[i], 8, ack);
            check("bad ack", {7'h00, ack}, 8'h00);
            mdl.send(8'hFF, 8, ack);
            check("ignored ack", {7'h00, ack}, 8'h00);
            mdl.stop(); // abandon after missing ack
            check("ctrl kept", ctrl, 8'h04);
        end
        $display("test bad address done");
        // stop inside a byte drops it; the next transfer still works
        mdl.start();
        mdl.send(8'hEC, 8, ack);
        mdl.send(8'hF9, 4, ack);
        mdl.stop();
        check("partial", ctrl, 8'h04);
        mdl.start();
        mdl.send(8'hEC, 8, ack);
        mdl.send(8'hF9, 8, ack);
        mdl.stop();
        check("after stop", ctrl, 8'hF9);
        $display("test abort done");
        // second reset in mid-run
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        check("ctrl rst2", ctrl, 8'h00);
        check("gain rst2", gain_db, 8'hB4);
        rstn_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        check("shut rst2", {7'h00, shut}, 8'h01);
        mdl.start();
        mdl.send(8'hEC, 8, ack);
        mdl.send(8'h9A, 8, ack);
        mdl.stop();
        check("ctrl rst2 wr", ctrl, 8'h9A);
        $display("test second reset done");
        print_verdict();
    end
endmodule : gain_mute_ctl_tb
`default_nettype wire
